/* test_uio_uart_regs.sv */
// self-checking bench of the uart register block
`timescale 1ns/1ps
`default_nettype none
`include "uio_consts.svh"
module test_uio_uart_regs;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        rd = 1'b0, wr = 1'b0, tmo = 1'b0, xoff = 1'b0, stall = 1'b0;
    logic        cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, dcd_n = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wd = 8'h00, rdat, txd, rxd, lctl, mctl, sfn, sclk;
    logic        rv, rxv, rxr, txv, txr, fen, irq;
    logic [2:0]  rxe;
    logic [15:0] dvs;
    int          fail_count = 0, checked = 0, cyc = 0;
    logic [3:0]  ra[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    logic [7:0]  rz[6] = '{8'h00, 8'h00, 8'hc1, 8'h00, 8'h00, 8'h00};
    // free running clock
    always #50 mclk_in = ~mclk_in;
    // block under test and far side
    uio_uart_regs #(.CHANNEL(0), .FIFO_DEPTH(16)) u_uio_uart_regs (
        .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_rd_in(rd),
        .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
        .rx_valid_in(rxv), .rx_data_in(rxd), .rx_parity_err_in(rxe[0]),
        .rx_frame_err_in(rxe[1]), .rx_break_in(rxe[2]), .rx_timeout_in(tmo),
        .rx_ready_out(rxr), .tx_valid_out(txv), .tx_data_out(txd), .tx_ready_in(txr),
        .xoff_detect_in(xoff), .cts_n_in(cts_n), .dsr_n_in(dsr_n), .ri_n_in(ri_n),
        .dcd_n_in(dcd_n), .line_control_out(lctl), .modem_control_out(mctl),
        .special_function_out(sfn), .divisor_out(dvs), .sample_clock_out(sclk),
        .fifo_enable_out(fen), .irq_pending_out(irq));
    uio_serial_peer u_uio_serial_peer (
        .mclk_in(mclk_in), .rx_valid_out(rxv), .rx_data_out(rxd), .rx_err_out(rxe),
        .rx_ready_in(rxr), .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr),
        .stall_in(stall));
    // compare one value and count it
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // one write access
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr   <= 1'b1;
        addr <= a;
        wd   <= d;
        @(posedge mclk_in);
        wr   <= 1'b0;
    endtask
    // one read access, answer compared under a mask; a zero mask expects no answer
    task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge mclk_in);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk_in);
        rd   <= 1'b0;
        @(negedge mclk_in);
        chk("read data", {7'h00, m != 8'h00, e & m}, {7'h00, rv, rdat & m});
    endtask
    // counts and verdict
    task automatic results();
        $display("mismatches %0d of %0d comparisons", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang limit
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    // test sequence
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) rreg(ra[i], rz[i]);
        for (int i = 0; i < 7; i++) begin
            wreg(4'h1, 8'h01 << i);
            rreg(4'h1, 8'h01 << i);
        end
        wreg(4'h3, 8'h3b);
        wreg(4'h4, 8'h1c);
        wreg(4'h7, 8'ha5);
        rreg(4'h3, 8'h3b);
        rreg(4'h4, 8'h1c);
        rreg(4'h7, 8'ha5);
        wreg(4'hb, 8'hff);
        rreg(4'h3, 8'h3b);
        rreg(4'h8, 8'h00, 8'h00);
        wreg(4'h3, 8'hbb);
        wreg(4'h0, 8'h12);
        wreg(4'h1, 8'h34);
        wreg(4'h2, 8'h56);
        chk("divisor", 16'h3412, dvs);
        rreg(4'h2, 8'h56);
        wreg(4'h3, 8'h3b);
        rreg(4'h1, 8'h40);
        chk("tx irq", 16'h0000, {14'h0000, txv, irq});
        chk("sclk sfn", 16'h56a5, {sclk, sfn});
        @(posedge mclk_in) stall <= 1'b1;
        wreg(4'h1, 8'h02);
        wreg(4'h0, 8'h5c);
        wreg(4'h0, 8'h77);
        stall <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk("tx taken", 16'h035c,
            {7'(u_uio_serial_peer.taken), irq, u_uio_serial_peer.got});
        rreg(4'h2, `UIO_IID_TXEMPTY);
        rreg(4'h2, `UIO_IID_NONE);
        wreg(4'h1, 8'h07);
        u_uio_serial_peer.send(8'h3c, 3'h0);
        rreg(4'h2, `UIO_IID_RXDATA);
        rreg(4'h0, 8'h3c);
        u_uio_serial_peer.send(8'h99, 3'h7);
        rreg(4'h2, `UIO_IID_RXERR);
        rreg(4'h5, 8'h9d, 8'h9f);
        rreg(4'h2, `UIO_IID_RXDATA);
        rreg(4'h0, 8'h99);
        @(posedge mclk_in) tmo <= 1'b1;
        @(posedge mclk_in) tmo <= 1'b0;
        rreg(4'h2, `UIO_IID_RXTMO);
        rreg(4'h0, 8'h99);
        rreg(4'h2, `UIO_IID_NONE);
        wreg(4'h1, 8'h48);
        cts_n <= 1'b0;
        repeat (4) @(posedge mclk_in);
        rreg(4'h2, `UIO_IID_MODEM);
        rreg(4'h6, 8'h88);
        rreg(4'h2, `UIO_IID_HSHAKE);
        wreg(4'h1, 8'h10);
        xoff <= 1'b1;
        @(posedge mclk_in) xoff <= 1'b0;
        rreg(4'h2, `UIO_IID_XOFF);
        wreg(4'h1, 8'h20);
        wreg(4'h4, 8'h1f);
        rreg(4'h2, `UIO_IID_HSHAKE);
        rreg(4'h2, `UIO_IID_NONE);
        wreg(4'h1, 8'h00);
        wreg(4'h2, 8'h01);
        for (int i = 1; i <= 16; i++) u_uio_serial_peer.send(8'(i), 3'h0);
        @(negedge mclk_in);
        chk("fifo state", 16'h0002, {14'h0000, fen, rxr});
        for (int i = 1; i <= 16; i++) rreg(4'h0, 8'(i));
        u_uio_serial_peer.send(8'h61, 3'h0);
        u_uio_serial_peer.send(8'h62, 3'h0);
        wreg(4'h2, 8'h03);
        repeat (2) @(posedge mclk_in);
        rreg(4'h5, 8'h00, 8'h01);
        u_uio_serial_peer.send(8'h63, 3'h0);
        rreg(4'h0, 8'h63);
        results();
    end
endmodule
`default_nettype wire

/* uio_consts.svh */
// offsets, field positions, reset values and codes of the uart io register block
`ifndef UIO_CONSTS_SVH
`define UIO_CONSTS_SVH

// ****************************************************************
// register offsets inside one channel block
// ****************************************************************
`define UIO_OFF_DATA     3'h0
`define UIO_OFF_IEN      3'h1
`define UIO_OFF_IID      3'h2
`define UIO_OFF_LCTL     3'h3
`define UIO_OFF_MCTL     3'h4
`define UIO_OFF_LST      3'h5
`define UIO_OFF_MST      3'h6
`define UIO_OFF_SFN      3'h7

// ****************************************************************
// field positions
// ****************************************************************
`define UIO_DIV_ACCESS_BIT 7
`define UIO_FCR_EN_BIT     0
`define UIO_FCR_RXF_BIT    1
`define UIO_IEN_RXD        0
`define UIO_IEN_TXE        1
`define UIO_IEN_RXS        2
`define UIO_IEN_MST        3
`define UIO_IEN_XOF        4
`define UIO_IEN_RTS        5
`define UIO_IEN_CTS        6

// ****************************************************************
// reset values
// ****************************************************************
`define UIO_RST_BYTE     8'h00
`define UIO_RST_SYNC     4'hf

// ****************************************************************
// identification codes, the idle code is also the reset value
// ****************************************************************
`define UIO_IID_NONE     8'hc1
`define UIO_IID_RXERR    8'hc6
`define UIO_IID_RXDATA   8'hc4
`define UIO_IID_RXTMO    8'hcc
`define UIO_IID_TXEMPTY  8'hc2
`define UIO_IID_MODEM    8'hc0
`define UIO_IID_XOFF     8'hd0
`define UIO_IID_HSHAKE   8'he0

`endif

/* uio_pkg.sv */
// types of the uart io register block
package uio_pkg;

    // whole state of the register block
    typedef struct packed {
        logic [7:0] rdata;
        logic       rvalid;
        logic [7:0] rx_last;
        logic [7:0] tx_hold;
        logic       tx_full;
        logic [7:0] ien;
        logic [7:0] lctl;
        logic [7:0] mctl;
        logic [7:0] sfn;
        logic [7:0] fctl;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] sclk;
        logic [3:0] lerr;
        logic       rx_tmo;
        logic       thre_irq;
        logic [3:0] mdelta;
        logic [3:0] msync1;
        logic [3:0] msync2;
        logic [3:0] mprev;
        logic       xoff_irq;
        logic       rtsdtr_irq;
        logic       ctsdsr_irq;
        logic       irq;
    } uio_state_t;

endpackage

/* uio_regs_properties.sv */
// checker of the register block port behaviour
`timescale 1ns/1ps
`default_nettype none
module uio_regs_chk #(
    parameter int CHANNEL = 0
) (
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        rst_in,
    // register access
    input wire logic [3:0]  reg_addr_in,
    input wire logic        reg_rd_in,
    input wire logic        reg_wr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        reg_rvalid_out,
    // transmitter and configuration
    input wire logic        tx_valid_out,
    input wire logic [7:0]  tx_data_out,
    input wire logic        tx_ready_in,
    input wire logic [7:0]  line_control_out,
    input wire logic [7:0]  modem_control_out,
    input wire logic [15:0] divisor_out,
    input wire logic        fifo_enable_out
);
    // ********
    // properties
    // ********
    logic       own;
    logic       dv;
    logic       w;
    logic [2:0] off;
    // access aimed at this channel, divisor window, offset
    assign own = (reg_addr_in[3] == 1'(CHANNEL));
    assign dv  = line_control_out[7];
    assign w   = reg_wr_in && own;
    assign off = reg_addr_in[2:0];
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    property p_rvalid; reg_rvalid_out == $past(reg_rd_in && own); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer wrong");
    property p_iid;
        reg_rd_in && own && !dv && off == 3'h2 |=>
            reg_rdata_out[7:6] == 2'b11 && reg_rdata_out[0] == (reg_rdata_out == 8'hc1);
    endproperty
    a_iid: assert property (p_iid) else $error("identification code malformed");
    property p_txload;
        w && !dv && off == 3'h0 && !tx_valid_out |=>
            tx_valid_out && tx_data_out == $past(reg_wdata_in);
    endproperty
    a_txload: assert property (p_txload) else $error("transmit byte not loaded");
    property p_txhold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
    endproperty
    a_txhold: assert property (p_txhold) else $error("transmit byte not held");
    property p_div;
        w && dv && off[2:1] == 2'b00 |=> ($past(off[0]) ? divisor_out[15:8] : divisor_out[7:0])
            == $past(reg_wdata_in);
    endproperty
    a_div: assert property (p_div) else $error("divisor byte not loaded");
    property p_fen; w && !dv && off == 3'h2 |=> fifo_enable_out == $past(reg_wdata_in[0]);
    endproperty
    a_fen: assert property (p_fen) else $error("fifo mode not taken");
    property p_lctl; w && off == 3'h3 |=> line_control_out == $past(reg_wdata_in); endproperty
    a_lctl: assert property (p_lctl) else $error("line control not loaded");
    property p_mctl; w && off == 3'h4 |=> modem_control_out == $past(reg_wdata_in); endproperty
    a_mctl: assert property (p_mctl) else $error("modem control not loaded");
    // main scenarios reached
    c_iid: cover property (reg_rvalid_out && reg_rdata_out != 8'hc1);
    c_stall: cover property (tx_valid_out && !tx_ready_in ##1 tx_valid_out);
    c_div: cover property (w && dv);
endmodule
bind uio_uart_regs uio_regs_chk #(.CHANNEL(CHANNEL)) u_uio_regs_chk (
    .mclk_in, .rst_in, .reg_addr_in, .reg_rd_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_rvalid_out, .tx_valid_out, .tx_data_out, .tx_ready_in,
    .line_control_out, .modem_control_out, .divisor_out, .fifo_enable_out);
`default_nettype wire

/* uio_serial_peer.sv */
// far side model: receiver offering characters, transmitter taking them
`timescale 1ns/1ps
`default_nettype none
module uio_serial_peer (
    // clock
    input wire logic        mclk_in,
    // receive path into the block
    output logic            rx_valid_out = 1'b0,
    output logic [7:0]      rx_data_out = 8'h00,
    output logic [2:0]      rx_err_out = 3'h0,
    input wire logic        rx_ready_in,
    // transmit path out of the block
    input wire logic        tx_valid_in,
    input wire logic [7:0]  tx_data_in,
    output logic            tx_ready_out,
    // no transmit answer while high
    input wire logic        stall_in
);
    logic [7:0] got = 8'h00;
    int         taken = 0;
    // offer one character with its error flags, hold it until taken
    task automatic send(input logic [7:0] d, input logic [2:0] e);
        @(posedge mclk_in);
        rx_valid_out <= 1'b1;
        rx_data_out  <= d;
        rx_err_out   <= e;
        @(negedge mclk_in);
        while (!rx_ready_in) @(negedge mclk_in);
        @(posedge mclk_in);
        rx_valid_out <= 1'b0;
        rx_data_out  <= ~d; // released lines do not keep the old value
        rx_err_out   <= ~e;
    endtask
    // transmitter takes a character whenever it is not stalled
    assign tx_ready_out = !stall_in;
    always @(posedge mclk_in) begin
        if (tx_valid_in && tx_ready_out) begin
            got   <= tx_data_in;
            taken <= taken + 1;
        end
    end
endmodule
`default_nettype wire

/* uio_uart_regs.sv */
// receive fifo and register block of one uart channel
//
// Notes on behaviour
// - each channel decodes an 8-byte block, channel 0 at 000h, channel 1 at 008h
// - reading offset 00h without divisor access returns received character, resets 00h
// - writing offset 00h without divisor access loads transmit character, resets 00h
// - offset 02h reads identification, writes go to fifo control
// - enable 01h, line control 03h, modem control 04h, status 05h/06h, special 07h
// - divisor access bit set maps 00h/01h/02h to divisor low, high, sample clock
// - enable bit 0 gates receive data ready interrupt, resets 0
// - enable bit 1 gates transmit holding empty interrupt, resets 0
// - enable bit 2 gates receive line status interrupt, resets 0
// - enable bit 3 gates modem status change interrupt, resets 0
// - enable bit 4 gates xoff or special character interrupt, resets 0
// - enable bit 5 gates rts or dtr change interrupt, resets 0
// - enable bit 6 gates cts or dsr change interrupt; bit 7 reserved
// - identification bit 0 low when pending, high when idle; resets c1h
// - fifo control bit 0 enables fifo mode
// - fifo control bit 1 flushes the receive fifo and clears itself
`timescale 1ns/1ps
`default_nettype none
`include "uio_consts.svh"

// ****************************************************************
// receive fifo
// ****************************************************************
module uio_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // control
    input  wire logic             flush_in,
    input  wire logic             single_in,
    // filling side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // draining side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          rdy;
    } uio_fifo_st_t;

    uio_fifo_st_t     st_ff;
    uio_fifo_st_t     nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic             push;
    logic             pop;
    logic [AW:0]      cap;

    // refuse depths the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("uio_fifo: DEPTH must be a power of two of at least 2");
    end

    // handshakes; a flush drops any transfer of its cycle
    assign push          = in_valid_in && st_ff.rdy && !flush_in;
    assign pop           = out_ready_in && (st_ff.cnt != '0) && !flush_in;
    assign in_ready_out  = st_ff.rdy;
    assign out_valid_out = (st_ff.cnt != '0);
    assign out_data_out  = mem_ff[st_ff.rp];
    // without fifo mode only one character is held
    assign cap           = single_in ? (AW+1)'(1) : (AW+1)'(DEPTH);

    // pointer and fill count update
    always_comb begin
        nxt_st = st_ff;
        if (push) nxt_st.wp = st_ff.wp + 1'b1;
        if (pop) nxt_st.rp = st_ff.rp + 1'b1;
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_in) begin
            nxt_st.wp  = st_ff.rp;
            nxt_st.cnt = '0;
        end
        nxt_st.rdy = (nxt_st.cnt < cap);
        if (rst_in) begin
            nxt_st     = '0;
            nxt_st.rdy = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        st_ff <= nxt_st;
    end

    // storage
    always_ff @(posedge clk_in) begin
        if (push) mem_ff[st_ff.wp] <= in_data_in;
    end
endmodule

// ****************************************************************
// register block of one channel
// ****************************************************************
module uio_uart_regs #(
    parameter int CHANNEL    = 0,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // register access, offset from the first base address
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic        reg_rd_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic [7:0]       reg_rdata_out,
    output logic             reg_rvalid_out,
    // receiver side
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic        rx_parity_err_in,
    input  wire logic        rx_frame_err_in,
    input  wire logic        rx_break_in,
    input  wire logic        rx_timeout_in,
    output logic             rx_ready_out,
    // transmitter side
    output logic             tx_valid_out,
    output logic [7:0]       tx_data_out,
    input  wire logic        tx_ready_in,
    // flow control event
    input  wire logic        xoff_detect_in,
    // modem pins, asynchronous
    input  wire logic        cts_n_in,
    input  wire logic        dsr_n_in,
    input  wire logic        ri_n_in,
    input  wire logic        dcd_n_in,
    // configuration to the serial logic, interrupt request
    output logic [7:0]       line_control_out,
    output logic [7:0]       modem_control_out,
    output logic [7:0]       special_function_out,
    output logic [15:0]      divisor_out,
    output logic [7:0]       sample_clock_out,
    output logic             fifo_enable_out,
    output logic             irq_pending_out
);
    localparam logic CHAN_BIT = 1'(CHANNEL);

    // refuse channels and depths the decoder cannot serve
    if (CHANNEL < 0 || CHANNEL > 1 || FIFO_DEPTH < 2) begin : g_chk
        $error("uio_uart_regs: CHANNEL must be 0 or 1");
    end

    uio_pkg::uio_state_t st_ff;
    uio_pkg::uio_state_t nxt_st;

    logic       div_acc;
    logic       rd_go;
    logic       wr_go;
    logic       rd_rx;
    logic       rx_push;
    logic       rx_ovr;
    logic       f_valid;
    logic [7:0] f_data;
    logic [7:1] pend;
    logic [7:0] iid;
    logic [7:0] lst;
    logic [7:0] mst;
    logic [3:0] mchg;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // address hits this channel at the given offset
    function automatic logic uio_at(input logic [3:0] a, input logic [2:0] off);
        return (a[3] == CHAN_BIT) && (a[2:0] == off);
    endfunction

    // pending source with the lowest level number wins
    function automatic logic [7:0] uio_iid(input logic [7:1] p);
        logic [7:0] c;
        c = `UIO_IID_NONE;
        if (p[7]) c = `UIO_IID_HSHAKE;
        if (p[6]) c = `UIO_IID_XOFF;
        if (p[5]) c = `UIO_IID_MODEM;
        if (p[4]) c = `UIO_IID_TXEMPTY;
        if (p[3]) c = `UIO_IID_RXTMO;
        if (p[2]) c = `UIO_IID_RXDATA;
        if (p[1]) c = `UIO_IID_RXERR;
        return c;
    endfunction

    // ****************************************************************
    // receive fifo
    // ****************************************************************
    uio_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in        (mclk_in),
        .rst_in        (rst_in),
        .flush_in      (st_ff.fctl[`UIO_FCR_RXF_BIT]),
        .single_in     (!st_ff.fctl[`UIO_FCR_EN_BIT]),
        .in_valid_in   (rx_valid_in),
        .in_data_in    (rx_data_in),
        .in_ready_out  (rx_ready_out),
        .out_valid_out (f_valid),
        .out_data_out  (f_data),
        .out_ready_in  (rd_rx)
    );

    // ****************************************************************
    // access decode and derived status
    // ****************************************************************
    // access strobes and receive side events
    assign div_acc = st_ff.lctl[`UIO_DIV_ACCESS_BIT];
    assign rd_go   = reg_rd_in && (reg_addr_in[3] == CHAN_BIT);
    assign wr_go   = reg_wr_in && (reg_addr_in[3] == CHAN_BIT);
    assign rd_rx   = reg_rd_in && uio_at(reg_addr_in, `UIO_OFF_DATA) && !div_acc;
    assign rx_push = rx_valid_in && rx_ready_out;
    assign rx_ovr  = rx_valid_in && !rx_ready_out;

    // enabled pending sources
    assign pend[1] = st_ff.ien[`UIO_IEN_RXS] && (st_ff.lerr != 4'h0);
    assign pend[2] = st_ff.ien[`UIO_IEN_RXD] && f_valid;
    assign pend[3] = st_ff.ien[`UIO_IEN_RXD] && st_ff.rx_tmo;
    assign pend[4] = st_ff.ien[`UIO_IEN_TXE] && st_ff.thre_irq;
    assign pend[5] = st_ff.ien[`UIO_IEN_MST] && (st_ff.mdelta != 4'h0);
    assign pend[6] = st_ff.ien[`UIO_IEN_XOF] && st_ff.xoff_irq;
    assign pend[7] = (st_ff.ien[`UIO_IEN_RTS] && st_ff.rtsdtr_irq)
                  || (st_ff.ien[`UIO_IEN_CTS] && st_ff.ctsdsr_irq);
    assign iid     = uio_iid(pend);

    // line status: error summary, empties, errors, data ready
    assign lst = {(st_ff.lerr != 4'h0), !st_ff.tx_full, !st_ff.tx_full,
                  st_ff.lerr[3], st_ff.lerr[2], st_ff.lerr[1], st_ff.lerr[0], f_valid};

    // modem status: present levels (cts dsr ri dcd) and changes
    assign mst = {~st_ff.msync2, st_ff.mdelta};

    // changes seen on the synchronised modem pins
    assign mchg[3] = st_ff.msync2[3] ^ st_ff.mprev[3];
    assign mchg[2] = st_ff.msync2[2] ^ st_ff.mprev[2];
    assign mchg[1] = st_ff.msync2[1] && !st_ff.mprev[1];   // ring trailing edge
    assign mchg[0] = st_ff.msync2[0] ^ st_ff.mprev[0];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.fctl[`UIO_FCR_RXF_BIT] = 1'b0;
        nxt_st.rvalid = rd_go;
        nxt_st.irq = (pend != 7'h00);

        // modem pin synchronisers
        nxt_st.msync1 = {cts_n_in, dsr_n_in, ri_n_in, dcd_n_in};
        nxt_st.msync2 = st_ff.msync1;
        nxt_st.mprev  = st_ff.msync2;

        // read data and clears caused by reads
        if (rd_go) begin
            case (reg_addr_in[2:0])
                `UIO_OFF_DATA: begin
                    if (div_acc) nxt_st.rdata = st_ff.div_lo;
                    else nxt_st.rdata = f_valid ? f_data : st_ff.rx_last;
                end
                `UIO_OFF_IEN: nxt_st.rdata = div_acc ? st_ff.div_hi : st_ff.ien;
                `UIO_OFF_IID: nxt_st.rdata = div_acc ? st_ff.sclk : iid;
                `UIO_OFF_LCTL: nxt_st.rdata = st_ff.lctl;
                `UIO_OFF_MCTL: nxt_st.rdata = st_ff.mctl;
                `UIO_OFF_LST: begin
                    nxt_st.rdata = lst;
                    nxt_st.lerr  = 4'h0;
                end
                `UIO_OFF_MST: begin
                    nxt_st.rdata  = mst;
                    nxt_st.mdelta = 4'h0;
                end
                default: nxt_st.rdata = st_ff.sfn;
            endcase
        end

        // a character read also retires the time-out
        if (rd_rx) begin
            nxt_st.rx_last = f_valid ? f_data : st_ff.rx_last;
            nxt_st.rx_tmo  = 1'b0;
        end

        // reading the identification retires the transmit empty, xoff and handshake sources shown
        if (rd_go && reg_addr_in[2:0] == `UIO_OFF_IID && !div_acc) begin
            if (iid == `UIO_IID_TXEMPTY) nxt_st.thre_irq = 1'b0;
            if (iid == `UIO_IID_XOFF) nxt_st.xoff_irq = 1'b0;
            if (iid == `UIO_IID_HSHAKE) begin
                nxt_st.rtsdtr_irq = 1'b0;
                nxt_st.ctsdsr_irq = 1'b0;
            end
        end

        // transmitter takes the held character
        if (st_ff.tx_full && tx_ready_in) nxt_st.tx_full = 1'b0;

        // register writes
        if (wr_go) begin
            case (reg_addr_in[2:0])
                `UIO_OFF_DATA: begin
                    if (div_acc) begin
                        nxt_st.div_lo = reg_wdata_in;
                    end else if (!st_ff.tx_full || tx_ready_in) begin
                        nxt_st.tx_hold  = reg_wdata_in;
                        nxt_st.tx_full  = 1'b1;
                        nxt_st.thre_irq = 1'b0;
                    end
                end
                `UIO_OFF_IEN: begin
                    if (div_acc) begin
                        nxt_st.div_hi = reg_wdata_in;
                    end else begin
                        nxt_st.ien = reg_wdata_in;
                    end
                end
                `UIO_OFF_IID: begin
                    if (div_acc) begin
                        nxt_st.sclk = reg_wdata_in;
                    end else begin
                        nxt_st.fctl = reg_wdata_in;
                    end
                end
                `UIO_OFF_LCTL: nxt_st.lctl = reg_wdata_in;
                `UIO_OFF_MCTL: begin
                    nxt_st.mctl = reg_wdata_in;
                    if (reg_wdata_in[1:0] != st_ff.mctl[1:0]) nxt_st.rtsdtr_irq = 1'b1;
                end
                `UIO_OFF_SFN: nxt_st.sfn = reg_wdata_in;
                default: nxt_st.sfn = st_ff.sfn;  // status offsets ignore writes
            endcase
        end

        // hardware events, applied last so that they beat any clear
        if (st_ff.tx_full && tx_ready_in) nxt_st.thre_irq = 1'b1;
        nxt_st.lerr[1] = nxt_st.lerr[1] | (rx_push && rx_parity_err_in);
        nxt_st.lerr[2] = nxt_st.lerr[2] | (rx_push && rx_frame_err_in);
        nxt_st.lerr[3] = nxt_st.lerr[3] | (rx_push && rx_break_in);
        if (rx_ovr) nxt_st.lerr[0] = 1'b1;
        if (rx_timeout_in) nxt_st.rx_tmo = 1'b1;
        if (xoff_detect_in) nxt_st.xoff_irq = 1'b1;
        nxt_st.mdelta = nxt_st.mdelta | mchg;
        if (mchg[3] || mchg[2]) nxt_st.ctsdsr_irq = 1'b1;

        // synchronous reset
        if (rst_in) begin
            nxt_st         = '0;
            nxt_st.rdata   = `UIO_RST_BYTE;
            nxt_st.rx_last = `UIO_RST_BYTE;
            nxt_st.tx_hold = `UIO_RST_BYTE;
            nxt_st.ien     = `UIO_RST_BYTE;
            nxt_st.msync1  = `UIO_RST_SYNC;
            nxt_st.msync2  = `UIO_RST_SYNC;
            nxt_st.mprev   = `UIO_RST_SYNC;
        end
    end

    // state register
    always_ff @(posedge mclk_in) begin
        st_ff <= nxt_st;
    end

    // ****************************************************************
    // outputs, all taken from state flops
    // ****************************************************************
    assign reg_rdata_out        = st_ff.rdata;
    assign reg_rvalid_out       = st_ff.rvalid;
    assign tx_valid_out         = st_ff.tx_full;
    assign tx_data_out          = st_ff.tx_hold;
    assign line_control_out     = st_ff.lctl;
    assign modem_control_out    = st_ff.mctl;
    assign special_function_out = st_ff.sfn;
    assign divisor_out          = {st_ff.div_hi, st_ff.div_lo};
    assign sample_clock_out     = st_ff.sclk;
    assign fifo_enable_out      = st_ff.fctl[`UIO_FCR_EN_BIT];
    assign irq_pending_out      = st_ff.irq;
endmodule

`default_nettype wire
